/* File: design/uart_irq_consts.vh */
/*
 Constants for the UART interrupt, sleep, time-out, break and baud block:
 register offsets, field positions, reset values, identification codes.
 Assumes inclusion by bare name from design files only.
*/
`ifndef UART_IRQ_CONSTS_VH
`define UART_IRQ_CONSTS_VH

`define A_DATA      6'h00
`define A_INT_EN    6'h04
`define A_INT_ID    6'h08
`define A_LINE_CTL  6'h0C
`define A_MODEM_CTL 6'h10
`define A_LINE_STAT 6'h14
`define A_ENH_FEAT  6'h18
`define A_DIV_LOW   6'h1C
`define A_DIV_HIGH  6'h20
`define A_SAMP_CNT  6'h24
`define A_SAMP_COMP 6'h28
`define A_FIFO_CTL  6'h2C
`define A_RX_TRIG   6'h30
`define A_TX_TRIG   6'h34
`define A_GPIO_IEN  6'h38

`define FIFO_DEPTH  7'h40
`define LCR_RESET   8'h1D
`define LCR_BREAK   6
`define MCR_PRESC   7
`define EFR_ENH     4
`define IER_RXD     0
`define IER_THR     1
`define IER_LSR     2
`define IER_MSR     3
`define IER_SLEEP   4
`define IER_XOFF    5
`define IER_HSK     6
`define SAMPLE_BASE 8'h10
`define TIMEOUT_CHARS 3'h4

`define ID_NONE  6'h01
`define ID_LSR   6'h06
`define ID_TOUT  6'h0C
`define ID_RXD   6'h04
`define ID_THR   6'h02
`define ID_MSR   6'h00
`define ID_GPIO  6'h30
`define ID_XOFF  6'h10
`define ID_HSK   6'h20

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: design/uart_irq_sleep_baud_gen.v */
/*
 Interrupt prioritisation, receive/transmit FIFOs with error tracking,
 receive time-out, break detect and send, sleep control and baud generator
 of a single-channel UART, with an AXI4-Lite register slave.
 Assumes the serial shifters sit outside and talk through the rx/tx ports,
 all synchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uart_irq_consts.vh"

module uart_irq_sleep_baud_gen (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_awvalid,
	output reg         o_awready,
	input  wire [5:0]  i_awaddr,
	input  wire        i_wvalid,
	output reg         o_wready,
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	output reg         o_bvalid,
	input  wire        i_bready,
	output reg  [1:0]  o_bresp,
	input  wire        i_arvalid,
	output reg         o_arready,
	input  wire [5:0]  i_araddr,
	output reg         o_rvalid,
	input  wire        i_rready,
	output reg  [31:0] o_rdata,
	output reg  [1:0]  o_rresp,
	input  wire        i_rx_pin,
	input  wire        i_rx_busy,
	input  wire        i_rx_char_valid,
	input  wire [7:0]  i_rx_char,
	input  wire [2:0]  i_rx_char_err,
	input  wire        i_rx_stop_centre,
	input  wire        i_tx_pop,
	input  wire        i_tx_shift_busy,
	input  wire        i_tx_serial,
	input  wire        i_modem_change,
	input  wire        i_gpio_change,
	input  wire        i_xoff_detect,
	input  wire        i_xon_detect,
	input  wire        i_special_detect,
	input  wire        i_handshake_release,
	output reg         o_tx,
	output reg  [7:0]  o_tx_data,
	output reg         o_tx_avail,
	output reg         o_sample_tick,
	output reg         o_bit_tick,
	output reg         o_sleep,
	output reg         o_irq_n
);

	reg  [7:0]  interrupt_enable_reg;
	reg  [7:0]  line_control_reg;
	reg  [7:0]  modem_control_reg;
	reg  [7:0]  enhanced_feature_reg;
	reg  [7:0]  divisor_low_byte;
	reg  [7:0]  divisor_high_byte;
	reg  [7:0]  sample_count_setting;
	reg  [7:0]  sample_compensation_setting;
	reg         fifo_enable;
	reg  [6:0]  rx_trigger;
	reg  [6:0]  tx_trigger;
	reg  [7:0]  gpio_interrupt_enable;

	reg  [10:0] rx_mem [0:63];
	reg  [7:0]  tx_mem [0:63];
	reg  [5:0]  rx_wr, rx_rd, tx_wr, tx_rd;
	reg  [6:0]  rx_count, tx_count, err_count;
	reg         overrun;
	reg         timeout_flag, modem_flag, gpio_flag, hsk_flag;
	reg         xoff_flow_flag, xoff_special_flag;
	reg  [5:0]  tout_count;
	reg  [9:0]  low_count;
	reg         break_armed;
	reg         rx_pin_q;
	reg  [1:0]  presc_count;
	reg  [15:0] div_count;
	reg  [7:0]  samp_count;

	reg         aw_held, w_held;
	reg  [5:0]  aw_addr;
	reg  [31:0] w_data;
	reg         w_lane0;

	// Decoded access strobes
	wire        wr_go = aw_held && w_held && !o_bvalid;
	wire        wr_en = wr_go && w_lane0;
	wire        rd_go = i_arvalid && o_arready;
	wire        rd_data = rd_go && (i_araddr == `A_DATA);
	wire        rd_iid = rd_go && (i_araddr == `A_INT_ID);
	wire        rd_lsr = rd_go && (i_araddr == `A_LINE_STAT);
	wire        thr_write = wr_en && (aw_addr == `A_DATA);

	wire        rx_empty = (rx_count == 7'h00);
	wire        rx_pop = rd_data && !rx_empty;
	wire        break_push;
	wire        rx_push = (i_rx_char_valid || break_push) && !o_sleep;
	wire        rx_take = rx_push && (rx_count != `FIFO_DEPTH || rx_pop);
	wire [10:0] rx_word = break_push ? 11'h400 : {i_rx_char_err, i_rx_char};
	wire        tx_take = thr_write && (tx_count != `FIFO_DEPTH);
	wire        tx_drop = i_tx_pop && (tx_count != 7'h00);
	wire [10:0] rx_head = rx_mem[rx_rd];

	// Character length: start, data, parity and stop bits
	wire [3:0]  char_bits = 4'h1 + 4'h5 + {2'h0, line_control_reg[1:0]}
		+ {3'h0, line_control_reg[3]} + (line_control_reg[2] ? 4'h2 : 4'h1);
	wire [7:0]  sample_rate = `SAMPLE_BASE - sample_count_setting
		+ sample_compensation_setting;
	wire [11:0] break_limit = {8'h00, char_bits} * {4'h0, sample_rate};
	wire        low_over = ({2'h0, low_count} > break_limit);
	assign break_push = low_over && break_armed;
	// Divisor writes restart the counters, so unwritten bytes cannot leave them unknown
	wire        div_wr = wr_en && (aw_addr == `A_DIV_LOW || aw_addr == `A_DIV_HIGH);
	wire [15:0] divisor = {divisor_high_byte, divisor_low_byte};
	wire        presc_hit = !modem_control_reg[`MCR_PRESC] || (presc_count == 2'h3);
	wire        div_hit = presc_hit && (div_count >= divisor - 16'h0001);
	wire        baud_run = (divisor != 16'h0000) && !o_sleep;
	wire        samp_tick = baud_run && div_hit;
	wire        bit_tick = samp_tick && (sample_rate != 8'h00)
		&& (samp_count >= sample_rate - 8'h01);

	wire        lsr_pend = interrupt_enable_reg[`IER_LSR] && (overrun || err_count != 7'h00);
	wire        tout_pend = interrupt_enable_reg[`IER_RXD] && timeout_flag;
	wire        rxd_pend = interrupt_enable_reg[`IER_RXD]
		&& (fifo_enable ? (rx_count > rx_trigger) : !rx_empty);
	// holding empty or space at or above trigger
	wire        thr_pend = interrupt_enable_reg[`IER_THR]
		&& (fifo_enable ? ((`FIFO_DEPTH - tx_count) >= tx_trigger) : (tx_count == 7'h00));
	wire        msr_pend = interrupt_enable_reg[`IER_MSR] && modem_flag;
	wire        gpio_pend = (gpio_interrupt_enable != 8'h00) && gpio_flag;
	wire        xoff_pend = interrupt_enable_reg[`IER_XOFF]
		&& (xoff_flow_flag || xoff_special_flag);
	wire        hsk_pend = interrupt_enable_reg[`IER_HSK] && hsk_flag;

	// only the highest-priority pending source is reported
	reg  [5:0]  next_ident;
	always @* begin
		if (lsr_pend)
			next_ident = `ID_LSR;
		else if (tout_pend)
			next_ident = `ID_TOUT;
		else if (rxd_pend)
			next_ident = `ID_RXD;
		else if (thr_pend)
			next_ident = `ID_THR;
		else if (msr_pend)
			next_ident = `ID_MSR;
		else if (gpio_pend)
			next_ident = `ID_GPIO;
		else if (xoff_pend)
			next_ident = `ID_XOFF;
		else if (hsk_pend)
			next_ident = `ID_HSK;
		else
			next_ident = `ID_NONE;
	end

	wire        quiet = !lsr_pend && !tout_pend && !rxd_pend && !msr_pend
		&& !gpio_pend && !xoff_pend && !hsk_pend;
	wire        idle = i_rx_pin && !i_rx_busy && (tx_count == 7'h00)
		&& !i_tx_shift_busy && rx_empty && quiet;
	wire        wake = (i_rx_pin != rx_pin_q) || i_modem_change || thr_write;
	wire        sleep_ok = enhanced_feature_reg[`EFR_ENH] && interrupt_enable_reg[`IER_SLEEP];

	wire [7:0]  line_status = {(err_count != 7'h00),
		(tx_count == 7'h00) && !i_tx_shift_busy, (tx_count == 7'h00),
		rx_empty ? 3'h0 : rx_head[10:8], overrun, !rx_empty};

	reg  [31:0] next_rdata;
	reg         next_rmiss;
	always @* begin
		next_rdata = 32'h0000_0000;
		next_rmiss = 1'b0;
		case (i_araddr)
		`A_DATA:      next_rdata[7:0] = rx_empty ? 8'h00 : rx_head[7:0];
		`A_INT_EN:    next_rdata[7:0] = interrupt_enable_reg;
		`A_INT_ID:    next_rdata[5:0] = next_ident;
		`A_LINE_CTL:  next_rdata[7:0] = line_control_reg;
		`A_MODEM_CTL: next_rdata[7:0] = modem_control_reg;
		`A_LINE_STAT: next_rdata[7:0] = line_status;
		`A_ENH_FEAT:  next_rdata[7:0] = enhanced_feature_reg;
		`A_DIV_LOW:   next_rdata[7:0] = divisor_low_byte;
		`A_DIV_HIGH:  next_rdata[7:0] = divisor_high_byte;
		`A_SAMP_CNT:  next_rdata[7:0] = sample_count_setting;
		`A_SAMP_COMP: next_rdata[7:0] = sample_compensation_setting;
		`A_FIFO_CTL:  next_rdata[0] = fifo_enable;
		`A_RX_TRIG:   next_rdata[6:0] = rx_trigger;
		`A_TX_TRIG:   next_rdata[6:0] = tx_trigger;
		`A_GPIO_IEN:  next_rdata[7:0] = gpio_interrupt_enable;
		default:      next_rmiss = 1'b1;
		endcase
	end

	// Write channel: address and data taken in either order
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 6'h00;
			w_data <= 32'h0000_0000;
			w_lane0 <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= `RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_lane0 <= i_wstrb[0];
				o_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (aw_addr > `A_GPIO_IEN || aw_addr[1:0] != 2'h0
					|| aw_addr == `A_INT_ID || aw_addr == `A_LINE_STAT)
					? `RESP_SLVERR : `RESP_OKAY;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// Read channel; one read outstanding
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `RESP_OKAY;
		end else if (rd_go) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= next_rdata;
			o_rresp <= next_rmiss ? `RESP_SLVERR : `RESP_OKAY;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// Divisor bytes keep their value over reset, only loaded by writes
	always @(posedge i_clk) begin
		if (wr_en && aw_addr == `A_DIV_LOW)
			divisor_low_byte <= w_data[7:0];
		if (wr_en && aw_addr == `A_DIV_HIGH)
			divisor_high_byte <= w_data[7:0];
		if (rx_take)
			rx_mem[rx_wr] <= rx_word;
		if (tx_take)
			tx_mem[tx_wr] <= w_data[7:0];
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			interrupt_enable_reg <= 8'h00;
			line_control_reg <= `LCR_RESET;
			modem_control_reg <= 8'h00;
			enhanced_feature_reg <= 8'h00;
			sample_count_setting <= 8'h00;
			sample_compensation_setting <= 8'h00;
			fifo_enable <= 1'b0;
			rx_trigger <= 7'h00;
			tx_trigger <= 7'h00;
			gpio_interrupt_enable <= 8'h00;
		end else if (wr_en) begin
			case (aw_addr)
			`A_INT_EN:    interrupt_enable_reg <= w_data[7:0];
			`A_LINE_CTL:  line_control_reg <= w_data[7:0];
			`A_MODEM_CTL: modem_control_reg <= w_data[7:0];
			`A_ENH_FEAT:  enhanced_feature_reg <= w_data[7:0];
			`A_SAMP_CNT:  sample_count_setting <= w_data[7:0];
			`A_SAMP_COMP: sample_compensation_setting <= w_data[7:0];
			`A_FIFO_CTL:  fifo_enable <= w_data[0];
			`A_RX_TRIG:   rx_trigger <= w_data[6:0];
			`A_TX_TRIG:   tx_trigger <= w_data[6:0];
			`A_GPIO_IEN:  gpio_interrupt_enable <= w_data[7:0];
			default:      fifo_enable <= fifo_enable;
			endcase
		end
	end

	// FIFO pointers, counts and the error tally
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_wr <= 6'h00;
			rx_rd <= 6'h00;
			rx_count <= 7'h00;
			tx_wr <= 6'h00;
			tx_rd <= 6'h00;
			tx_count <= 7'h00;
			err_count <= 7'h00;
			overrun <= 1'b0;
			o_tx_data <= 8'h00;
			o_tx_avail <= 1'b0;
		end else begin
			if (rx_take)
				rx_wr <= rx_wr + 6'h01;
			if (rx_pop)
				rx_rd <= rx_rd + 6'h01;
			rx_count <= rx_count + {6'h00, rx_take} - {6'h00, rx_pop};
			err_count <= err_count + {6'h00, rx_take && rx_word[10:8] != 3'h0}
				- {6'h00, rx_pop && rx_head[10:8] != 3'h0};
			// Overrun: set beats the status-read clear
			if (rx_push && !rx_take)
				overrun <= 1'b1;
			else if (rd_lsr)
				overrun <= 1'b0;
			if (tx_take)
				tx_wr <= tx_wr + 6'h01;
			if (tx_drop)
				tx_rd <= tx_rd + 6'h01;
			tx_count <= tx_count + {6'h00, tx_take} - {6'h00, tx_drop};
			// Head shown one cycle late; pop no faster than every other cycle
			o_tx_data <= tx_mem[tx_rd];
			o_tx_avail <= (tx_count != 7'h00) && !tx_drop;
		end
	end

	// Sticky interrupt sources; a new event beats its clear
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			modem_flag <= 1'b0;
			gpio_flag <= 1'b0;
			hsk_flag <= 1'b0;
			xoff_flow_flag <= 1'b0;
			xoff_special_flag <= 1'b0;
		end else begin
			if (i_modem_change)
				modem_flag <= 1'b1;
			else if (rd_iid && next_ident == `ID_MSR)
				modem_flag <= 1'b0;
			if (i_gpio_change)
				gpio_flag <= 1'b1;
			else if (rd_iid && next_ident == `ID_GPIO)
				gpio_flag <= 1'b0;
			if (i_handshake_release)
				hsk_flag <= 1'b1;
			else if (rd_iid && next_ident == `ID_HSK)
				hsk_flag <= 1'b0;
			// resume character clears stop, ident read clears special
			if (i_xoff_detect)
				xoff_flow_flag <= 1'b1;
			else if (i_xon_detect)
				xoff_flow_flag <= 1'b0;
			if (i_special_detect)
				xoff_special_flag <= 1'b1;
			else if (rd_iid)
				xoff_special_flag <= 1'b0;
		end
	end

	// Time-out and break watch, both paced by the baud generator
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tout_count <= 6'h00;
			timeout_flag <= 1'b0;
			low_count <= 10'h000;
			break_armed <= 1'b1;
		end else begin
			// restart at stop centre or FIFO read
			if (i_rx_stop_centre || rd_data || rx_empty)
				tout_count <= 6'h00;
			else if (bit_tick && !timeout_flag)
				tout_count <= tout_count + 6'h01;
			// four character times, data at or below trigger
			if (rd_data || rx_empty)
				timeout_flag <= 1'b0;
			else if (tout_count >= {3'h0, `TIMEOUT_CHARS} * {2'h0, char_bits}
				&& !(fifo_enable && rx_count > rx_trigger))
				timeout_flag <= 1'b1;
			// line low past a whole character
			if (i_rx_pin) begin
				low_count <= 10'h000;
				break_armed <= 1'b1;
			end else if (samp_tick && low_count != 10'h3FF) begin
				low_count <= low_count + 10'h001;
			end
			if (break_push)
				break_armed <= 1'b0;
		end
	end

	// divisor counter, no ticks when divisor is zero
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			presc_count <= 2'h0;
			div_count <= 16'h0000;
			samp_count <= 8'h00;
			o_sample_tick <= 1'b0;
			o_bit_tick <= 1'b0;
		end else begin
			o_sample_tick <= samp_tick;
			o_bit_tick <= bit_tick;
			if (!baud_run || div_wr) begin
				presc_count <= 2'h0;
				div_count <= 16'h0000;
				samp_count <= 8'h00;
			end else begin
				presc_count <= presc_count + 2'h1;
				if (div_hit)
					div_count <= 16'h0000;
				else if (presc_hit)
					div_count <= div_count + 16'h0001;
				if (bit_tick)
					samp_count <= 8'h00;
				else if (samp_tick)
					samp_count <= samp_count + 8'h01;
			end
		end
	end

	// Output pins, sleep state and interrupt line
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_pin_q <= 1'b1;
			o_tx <= 1'b1;
			o_sleep <= 1'b0;
			o_irq_n <= 1'b1;
		end else begin
			rx_pin_q <= i_rx_pin;
			// break bit forces the line low
			o_tx <= line_control_reg[`LCR_BREAK] ? 1'b0 : i_tx_serial;
			// divisor writes are the host's to avoid while asleep
			if (wake || !sleep_ok)
				o_sleep <= 1'b0;
			else if (idle)
				o_sleep <= 1'b1;
			// polled mode leaves the line high
			// low while anything enabled is pending
			o_irq_n <= (next_ident == `ID_NONE);
		end
	end

endmodule
`default_nettype wire

/* File: testbench/uart_irq_sleep_baud_gen_checker.sv */
/*
 Port-level checks of the UART interrupt, sleep, break and baud block.
 Assumes it is bound to the design top: one clock, async active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_irq_checker (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        o_awready,
	input wire logic        o_wready,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic        o_arready,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic        i_rx_pin,
	input wire logic        i_tx_shift_busy,
	input wire logic        i_tx_serial,
	input wire logic        i_modem_change,
	input wire logic        o_tx,
	input wire logic        o_tx_avail,
	input wire logic        o_sample_tick,
	input wire logic        o_sleep
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	AST_B_REFUSE: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write address or data taken while response open");
	AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid)
		else $error("write response dropped before handshake");
	AST_B_DONE: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response held after handshake");
	AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data changed before handshake");
	AST_R_REFUSE: assert property (o_rvalid |-> !o_arready)
		else $error("read address taken while data open");
	AST_TX_PATH: assert property (o_tx |-> $past(i_tx_serial))
		else $error("transmit line high without serial source high");
	AST_SLEEP_IDLE: assert property ($rose(o_sleep) |->
		$past(i_rx_pin) && !$past(i_tx_shift_busy) && !$past(o_tx_avail))
		else $error("sleep entered while not idle");
	AST_SLEEP_NO_TICK: assert property (o_sleep && $past(o_sleep) |-> !o_sample_tick)
		else $error("baud tick while asleep");
	AST_WAKE_MODEM: assert property (o_sleep && i_modem_change |-> ##[1:2] !o_sleep)
		else $error("no wake on modem change");
	AST_WAKE_RX: assert property (o_sleep && i_rx_pin != $past(i_rx_pin) |-> ##[1:2] !o_sleep)
		else $error("no wake on receive line change");
endmodule
bind uart_irq_sleep_baud_gen uart_irq_checker chk_u (
	.i_clk(i_clk), .i_rst(i_rst), .o_awready(o_awready), .o_wready(o_wready),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .o_arready(o_arready), .o_rvalid(o_rvalid),
	.i_rready(i_rready), .o_rdata(o_rdata), .i_rx_pin(i_rx_pin),
	.i_tx_shift_busy(i_tx_shift_busy), .i_tx_serial(i_tx_serial),
	.i_modem_change(i_modem_change), .o_tx(o_tx), .o_tx_avail(o_tx_avail),
	.o_sample_tick(o_sample_tick), .o_sleep(o_sleep)
);
`default_nettype wire

/* File: testbench/uart_far_end.sv */
/*
 Far-end model: remote receive front end and transmit shifter.
 Assumes the bench calls send and hold_low; idle serial lines are high.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_far_end (
	input  wire logic       i_clk,
	input  wire logic       i_tx_avail,
	output logic            o_rx_pin,
	output logic            o_rx_busy,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_char,
	output logic [2:0]      o_rx_err,
	output logic            o_stop_centre,
	output logic            o_tx_pop,
	output wire logic       o_tx_busy,
	output logic            o_tx_serial
);
	logic [4:0] cnt = 5'h00;
	assign o_tx_busy = (cnt != 5'h00);
	initial begin
		{o_rx_pin, o_rx_busy, o_rx_valid, o_stop_centre} = 4'h8;
		o_rx_char = 8'h00;
		o_rx_err = 3'h0;
		o_tx_pop = 1'b0;
		o_tx_serial = 1'b1;
	end
	// Pops spaced by the shift time, never back to back
	always @(posedge i_clk) begin
		o_tx_pop <= 1'b0;
		if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
			o_tx_serial <= ~o_tx_serial;
		end else if (i_tx_avail && !o_tx_pop) begin
			o_tx_pop <= 1'b1;
			cnt <= 5'h13;
		end else begin
			o_tx_serial <= 1'b1;
		end
	end
	task send(input logic [7:0] d, input logic [2:0] e);
		@(posedge i_clk);
		o_rx_pin <= 1'b0;
		o_rx_busy <= 1'b1;
		repeat (8) @(posedge i_clk);
		o_rx_pin <= 1'b1;
		o_rx_char <= d;
		o_rx_err <= e;
		{o_rx_valid, o_stop_centre} <= 2'h3;
		@(posedge i_clk);
		{o_rx_valid, o_stop_centre, o_rx_busy} <= 3'h0;
		// Stale bus shows a changing pattern
		o_rx_char <= ~d;
		o_rx_err <= ~e;
	endtask
	task hold_low(input int n);
		@(posedge i_clk);
		o_rx_pin <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_rx_pin <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* File: testbench/uart_irq_sleep_baud_gen_tb.sv */
/*
 Self-checking bench: register table, baud, interrupts, break, sleep.
 Assumes the design header, the checker and the far-end model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %0t: got %h exp %h", $time, g, e); end end
module uart_irq_sleep_baud_gen_tb;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic        i_arvalid = 1'b0, i_rready = 1'b0;
	logic [5:0]  i_awaddr = 6'h00, i_araddr = 6'h00, ev = 6'h00;
	logic [31:0] i_wdata = 32'h00000000;
	logic [3:0]  i_wstrb = 4'hF;
	wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx, o_tx_avail;
	wire         o_sample_tick, o_bit_tick, o_sleep, o_irq_n;
	wire  [1:0]  o_bresp, o_rresp;
	wire  [31:0] o_rdata;
	wire  [7:0]  o_tx_data, i_rx_char;
	wire  [2:0]  i_rx_char_err;
	wire         i_rx_pin, i_rx_busy, i_rx_char_valid, i_rx_stop_centre;
	wire         i_tx_pop, i_tx_shift_busy, i_tx_serial;
	int          err_count = 0, n_compared = 0, cyc = 0, n;
	logic [7:0]  d;
	logic [1:0]  rsp;
	// Rows: address, write data, read-back, write and read response
	logic [31:0] rows [0:11] = '{32'h0C030300, 32'h10000000, 32'h24000000, 32'h28000000,
		32'h2C010100, 32'h30010100, 32'h34000000, 32'h38010100, 32'h08FF0120,
		32'h3C550022, 32'h1C030300, 32'h20000000};
	// Event mask and identification code it should give
	logic [15:0] evr [0:4] = '{16'h0100, 16'h0230, 16'h0410, 16'h1010, 16'h2020};

	uart_irq_sleep_baud_gen dut_u (.i_clk(i_clk), .i_rst(i_rst),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
		.i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.i_rx_pin(i_rx_pin), .i_rx_busy(i_rx_busy), .i_rx_char_valid(i_rx_char_valid),
		.i_rx_char(i_rx_char), .i_rx_char_err(i_rx_char_err),
		.i_rx_stop_centre(i_rx_stop_centre), .i_tx_pop(i_tx_pop),
		.i_tx_shift_busy(i_tx_shift_busy), .i_tx_serial(i_tx_serial),
		.i_modem_change(ev[0]), .i_gpio_change(ev[1]), .i_xoff_detect(ev[2]),
		.i_xon_detect(ev[3]), .i_special_detect(ev[4]), .i_handshake_release(ev[5]),
		.o_tx(o_tx), .o_tx_data(o_tx_data), .o_tx_avail(o_tx_avail),
		.o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick), .o_sleep(o_sleep),
		.o_irq_n(o_irq_n));
	uart_far_end far_u (.i_clk(i_clk), .i_tx_avail(o_tx_avail), .o_rx_pin(i_rx_pin),
		.o_rx_busy(i_rx_busy), .o_rx_valid(i_rx_char_valid), .o_rx_char(i_rx_char),
		.o_rx_err(i_rx_char_err), .o_stop_centre(i_rx_stop_centre), .o_tx_pop(i_tx_pop),
		.o_tx_busy(i_tx_shift_busy), .o_tx_serial(i_tx_serial));

	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	task stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= {24'h000000, v};
		{i_awvalid, i_wvalid, i_bready} <= 3'h7;
		do begin
			@(posedge i_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1);
		rsp = o_bresp;
		i_bready <= 1'b0;
	endtask
	task chk(input logic [5:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_araddr <= a;
		{i_arvalid, i_rready} <= 2'h3;
		do begin
			@(posedge i_clk);
			if (o_arready) i_arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1);
		d = o_rdata[7:0];
		rsp = o_rresp;
		i_rready <= 1'b0;
		`CHK(d, e)
	endtask
	function logic tk(input bit b);
		return b ? o_bit_tick : o_sample_tick;
	endfunction
	// Second full interval, so a reprogrammed counter has settled
	task gap(input bit b);
		repeat (2) do @(posedge i_clk); while (tk(b) !== 1'b1);
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (tk(b) !== 1'b1 && n < 3000);
	endtask
	task ticks(input int c);
		n = 0;
		repeat (c) begin
			@(posedge i_clk);
			if (o_sample_tick !== 1'b0) n++;
		end
	endtask
	task pulse(input logic [5:0] m);
		@(posedge i_clk);
		ev <= m;
		@(posedge i_clk);
		ev <= 6'h00;
		repeat (2) @(posedge i_clk);
	endtask

	initial begin
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		chk(6'h08, 8'h01);
		chk(6'h0C, 8'h1D);
		chk(6'h14, 8'h60);
		`CHK(o_irq_n, 1'b1)
		$display("done reset values");
		// Divisor rows go in while sleep is still disabled
		for (int k = 0; k < 12; k++) begin
			wr(rows[k][29:24], rows[k][23:16]);
			`CHK(rsp, rows[k][5:4])
			chk(rows[k][29:24], rows[k][15:8]);
			`CHK(rsp, rows[k][1:0])
		end
		$display("done register table");
		gap(0);
		`CHK(n, 3)
		gap(1);
		`CHK(n, 48)
		wr(6'h10, 8'h80);
		gap(0);
		`CHK(n, 12)
		wr(6'h10, 8'h00);
		wr(6'h24, 8'h04);
		wr(6'h28, 8'h01);
		gap(1);
		`CHK(n, 39)
		wr(6'h1C, 8'h00);
		ticks(200);
		`CHK(n, 0)
		wr(6'h1C, 8'h01);
		wr(6'h24, 8'h00);
		wr(6'h28, 8'h00);
		$display("done baud");
		wr(6'h04, 8'h07);
		repeat (2) @(posedge i_clk);
		`CHK(o_irq_n, 1'b0)
		chk(6'h08, 8'h02);
		far_u.send(8'hA5, 3'h0);
		chk(6'h08, 8'h02);
		far_u.send(8'h5A, 3'h0);
		chk(6'h08, 8'h04);
		far_u.send(8'h3C, 3'h2);
		chk(6'h08, 8'h06);
		chk(6'h14, 8'hE1);
		chk(6'h00, 8'hA5);
		chk(6'h00, 8'h5A);
		chk(6'h14, 8'hE9);
		chk(6'h00, 8'h3C);
		chk(6'h14, 8'h60);
		wr(6'h04, 8'h00);
		repeat (2) @(posedge i_clk);
		`CHK(o_irq_n, 1'b1)
		$display("done priority and line status");
		wr(6'h04, 8'h01);
		far_u.send(8'h11, 3'h0);
		repeat (600) @(posedge i_clk);
		`CHK(o_irq_n, 1'b1)
		n = 0;
		while (o_irq_n !== 1'b0 && n < 2000) begin
			@(posedge i_clk);
			n++;
		end
		chk(6'h08, 8'h0C);
		chk(6'h00, 8'h11);
		chk(6'h08, 8'h01);
		far_u.hold_low(600);
		repeat (4) @(posedge i_clk);
		chk(6'h14, 8'hF1);
		chk(6'h00, 8'h00);
		$display("done time-out and break detect");
		wr(6'h0C, 8'h43);
		wr(6'h00, 8'h77);
		n = 0;
		repeat (20) begin
			@(posedge i_clk);
			if (o_tx !== 1'b0) n++;
		end
		`CHK(n, 0)
		wr(6'h0C, 8'h03);
		repeat (2) @(posedge i_clk);
		`CHK(o_tx, 1'b1)
		$display("done break send");
		wr(6'h04, 8'h68);
		for (int k = 0; k < 5; k++) begin
			pulse(evr[k][13:8]);
			`CHK(o_irq_n, 1'b0)
			chk(6'h08, evr[k][7:0]);
			if (k == 2) pulse(6'h08);
			chk(6'h08, 8'h01);
		end
		pulse(6'h21);
		chk(6'h08, 8'h00);
		chk(6'h08, 8'h20);
		$display("done event sources");
		wr(6'h04, 8'h10);
		repeat (5) @(posedge i_clk);
		`CHK(o_sleep, 1'b0)
		wr(6'h18, 8'h10);
		repeat (5) @(posedge i_clk);
		`CHK(o_sleep, 1'b1)
		ticks(50);
		`CHK(n, 0)
		wr(6'h00, 8'h5A);
		`CHK(o_sleep, 1'b0)
		repeat (40) @(posedge i_clk);
		`CHK(o_sleep, 1'b1)
		far_u.hold_low(2);
		repeat (20) @(posedge i_clk);
		pulse(6'h01);
		repeat (10) @(posedge i_clk);
		$display("done sleep");
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		chk(6'h0C, 8'h1D);
		chk(6'h04, 8'h00);
		chk(6'h08, 8'h01);
		`CHK(o_sleep, 1'b0)
		$display("done mid-run reset");
		stop_test();
	end
endmodule
`default_nettype wire
